// ### design/tps_pkg.sv
// Package for the timer / shared prescaler block: addresses, fields, resets, carriers
package tps_pkg;
  // Processor register addresses
  localparam logic [7:0] TPS_ADDR_TIMER_COUNT = 8'h01;
  localparam logic [7:0] TPS_ADDR_INTCTL_LO = 8'h0B;
  localparam logic [7:0] TPS_ADDR_INTCTL_HI = 8'h8B;
  localparam logic [7:0] TPS_ADDR_OPTION = 8'h81;
  localparam logic [7:0] TPS_ADDR_PORTA_DIR = 8'h85;

  // Option register fields
  localparam int TPS_OPT_SRC_BIT = 5;
  localparam int TPS_OPT_EDGE_BIT = 4;
  localparam int TPS_OPT_ASSIGN_BIT = 3;
  localparam int TPS_OPT_RATE_LSB = 0;
  localparam int TPS_RATE_W = 3;

  // Interrupt control fields
  localparam int TPS_INT_FLAG_BIT = 2;
  localparam int TPS_INT_ENABLE_BIT = 5;

  // Reset values
  localparam logic [7:0] TPS_OPTION_RST = 8'hFF;
  localparam logic [7:0] TPS_INTCTL_RST = 8'h00;
  localparam logic [7:0] TPS_TIMER_RST = 8'h00;
  localparam logic [5:0] TPS_PORTA_DIR_RST = 6'h3F;
  localparam int TPS_PORTA_DIR_W = 6;

  // Widths and timing
  localparam int TPS_PRESC_W = 8;
  localparam int TPS_WDT_POST_W = 16;
  localparam logic [1:0] TPS_WRITE_INHIBIT_CYCLES = 2'h2;

  // Processor register access carrier
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } tps_reg_req_s;

  // Mode of the shared prescaler
  typedef enum logic [1:0] {
    TPS_ASSIGN_TIMER = 2'b01,
    TPS_ASSIGN_WDT = 2'b10
  } tps_assign_e;
endpackage : tps_pkg

// ### design/tps_prescaler.sv
// Shared 8-bit prescaler: power-of-two divider with synchronous clear
`timescale 1ns/1ps
`default_nettype none
module tps_prescaler #(
  parameter int W = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clr,
  input wire logic tick_in,
  input wire logic [2:0] rate,
  input wire tps_pkg::tps_assign_e assign_mode,
  output logic tick_out
);
  import tps_pkg::*;

  typedef struct packed {
    logic [W-1:0] cnt;
  } tps_presc_state_s;

  tps_presc_state_s st_r;
  tps_presc_state_s st_nxt;
  logic [3:0] shift_amt;
  logic [W:0] mask;

  // Timer divides by 2^(rate+1), watchdog by 2^rate
  always_comb begin
    shift_amt = (assign_mode == TPS_ASSIGN_TIMER) ? ({1'b0, rate} + 4'h1) : {1'b0, rate};
    mask = ({{W{1'b0}}, 1'b1} << shift_amt) - {{W{1'b0}}, 1'b1};
    tick_out = tick_in && ((st_r.cnt & mask[W-1:0]) == mask[W-1:0]);
  end

  // Counter is never exposed; clear beats any pending tick
  always_comb begin
    st_nxt = st_r;
    if (clr) begin
      st_nxt.cnt = '0;
    end else if (tick_in) begin
      st_nxt.cnt = st_r.cnt + {{(W-1){1'b0}}, 1'b1};
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
endmodule : tps_prescaler
`default_nettype wire

// ### design/tps_timer.sv
// 8-bit timer with shared prescaler / watchdog postscaler assignment
`timescale 1ns/1ps
`default_nettype none
// Function
// - one 8-bit counter, timer or watchdog
// - option bit 3 assigns prescaler to watchdog
// - rate field selects power-of-two division
// - option bit 5 selects pin or cycles
// - option bit 4 selects falling pin edge
// - prescaler count has no software access
// - timer write clears prescaler in timer mode
// - watchdog clear clears prescaler in watchdog mode
// - assignment may change any time, no halt
// - watchdog has own 16-bit postscaler
// - unprescaled internal mode counts every cycle
// - timer write inhibits counting two cycles
// - roll-over FFh to 00h sets overflow flag
// - timer stops counting during sleep
module tps_timer (
  input wire logic clk,
  input wire logic rst_n,
  input wire tps_pkg::tps_reg_req_s reg_req,
  output logic [7:0] reg_rdata,
  input wire logic external_count_pin,
  input wire logic sleep_active,
  input wire logic watchdog_clear_instruction,
  input wire logic watchdog_base_tick,
  output logic overflow_flag,
  output logic watchdog_timeout,
  output logic [5:0] port_a_direction
);
  import tps_pkg::*;

  typedef struct packed {
    logic [7:0] timer_count;
    logic [7:0] interrupt_control;
    logic [7:0] timer_option;
    logic [TPS_PORTA_DIR_W-1:0] porta_dir;
    logic pin_prev;
    logic [1:0] inhibit;
    logic [7:0] rdata;
    logic [TPS_WDT_POST_W-1:0] wdt_post;
    logic wdt_timeout;
  } tps_state_s;

  tps_state_s st_r;
  tps_state_s st_nxt;

  logic count_source_select;
  logic count_edge_select;
  logic prescaler_assign;
  logic [TPS_RATE_W-1:0] prescale_rate_select;
  tps_assign_e assign_mode;
  logic wr_timer;
  logic wr_intctl;
  logic wr_option;
  logic wr_porta;
  logic pin_rise;
  logic pin_fall;
  logic src_event;
  logic presc_clr;
  logic presc_in;
  logic presc_out;
  logic timer_adv;
  logic wdt_adv;
  logic overflow_evt;

  // Option fields decoded straight from the live register, so reassignment is immediate
  always_comb begin
    count_source_select = st_r.timer_option[TPS_OPT_SRC_BIT];
    count_edge_select = st_r.timer_option[TPS_OPT_EDGE_BIT];
    prescaler_assign = st_r.timer_option[TPS_OPT_ASSIGN_BIT];
    prescale_rate_select = st_r.timer_option[TPS_OPT_RATE_LSB +: TPS_RATE_W];
    assign_mode = prescaler_assign ? TPS_ASSIGN_WDT : TPS_ASSIGN_TIMER;
  end

  // Register write decode
  always_comb begin
    wr_timer = reg_req.wr && (reg_req.addr == TPS_ADDR_TIMER_COUNT);
    wr_intctl = reg_req.wr && ((reg_req.addr == TPS_ADDR_INTCTL_LO) || (reg_req.addr == TPS_ADDR_INTCTL_HI));
    wr_option = reg_req.wr && (reg_req.addr == TPS_ADDR_OPTION);
    wr_porta = reg_req.wr && (reg_req.addr == TPS_ADDR_PORTA_DIR);
  end

  // Count source: pin edge or instruction cycle, frozen in sleep
  always_comb begin
    pin_rise = external_count_pin && !st_r.pin_prev;
    pin_fall = !external_count_pin && st_r.pin_prev;
    if (count_source_select) begin
      src_event = count_edge_select ? pin_fall : pin_rise;
    end else begin
      src_event = 1'b1;
    end
    if (sleep_active) begin
      src_event = 1'b0;
    end
  end

  // Prescaler routing; only one consumer owns it at a time
  always_comb begin
    if (assign_mode == TPS_ASSIGN_TIMER) begin
      presc_in = src_event && (st_r.inhibit == 2'h0);
      presc_clr = wr_timer;
      timer_adv = presc_out;
      wdt_adv = watchdog_base_tick;
    end else begin
      presc_in = watchdog_base_tick;
      presc_clr = watchdog_clear_instruction;
      timer_adv = src_event;
      wdt_adv = presc_out;
    end
  end

  // Shared prescaler; its count never reaches the read path
  tps_prescaler #(
    .W(TPS_PRESC_W)
  ) u_presc (
    .clk(clk),
    .rst_n(rst_n),
    .clr(presc_clr),
    .tick_in(presc_in),
    .rate(prescale_rate_select),
    .assign_mode(assign_mode),
    .tick_out(presc_out)
  );

  assign overflow_evt = timer_adv && (st_r.inhibit == 2'h0) && !wr_timer && (st_r.timer_count == 8'hFF);

  // Next-state logic for all registers
  always_comb begin
    st_nxt = st_r;
    st_nxt.pin_prev = external_count_pin;
    st_nxt.wdt_timeout = 1'b0;

    // Inhibit window after a timer write
    if (wr_timer) begin
      st_nxt.inhibit = TPS_WRITE_INHIBIT_CYCLES;
    end else if (st_r.inhibit != 2'h0) begin
      st_nxt.inhibit = st_r.inhibit - 2'h1;
    end

    // Timer count: a write wins over an increment in the same cycle
    if (wr_timer) begin
      st_nxt.timer_count = reg_req.wdata;
    end else if (timer_adv && (st_r.inhibit == 2'h0)) begin
      st_nxt.timer_count = st_r.timer_count + 8'h01;
    end

    // Interrupt control: overflow set beats software clear
    if (wr_intctl) begin
      st_nxt.interrupt_control = reg_req.wdata;
    end
    if (overflow_evt) begin
      st_nxt.interrupt_control[TPS_INT_FLAG_BIT] = 1'b1;
    end

    if (wr_option) begin
      st_nxt.timer_option = reg_req.wdata;
    end
    if (wr_porta) begin
      st_nxt.porta_dir = reg_req.wdata[TPS_PORTA_DIR_W-1:0];
    end

    // Dedicated watchdog postscaler, reset by the clear instruction
    if (watchdog_clear_instruction) begin
      st_nxt.wdt_post = '0;
    end else if (wdt_adv) begin
      st_nxt.wdt_post = st_r.wdt_post + {{(TPS_WDT_POST_W-1){1'b0}}, 1'b1};
      st_nxt.wdt_timeout = &st_r.wdt_post;
    end

    // Registered read data; unknown addresses read zero
    if (reg_req.rd) begin
      unique case (reg_req.addr)
        TPS_ADDR_TIMER_COUNT: st_nxt.rdata = st_r.timer_count;
        TPS_ADDR_INTCTL_LO: st_nxt.rdata = st_r.interrupt_control;
        TPS_ADDR_INTCTL_HI: st_nxt.rdata = st_r.interrupt_control;
        TPS_ADDR_OPTION: st_nxt.rdata = st_r.timer_option;
        TPS_ADDR_PORTA_DIR: st_nxt.rdata = {2'h0, st_r.porta_dir};
        default: st_nxt.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r.timer_count <= TPS_TIMER_RST;
      st_r.interrupt_control <= TPS_INTCTL_RST;
      st_r.timer_option <= TPS_OPTION_RST;
      st_r.porta_dir <= TPS_PORTA_DIR_RST;
      st_r.pin_prev <= 1'b0;
      st_r.inhibit <= 2'h0;
      st_r.rdata <= 8'h00;
      st_r.wdt_post <= '0;
      st_r.wdt_timeout <= 1'b0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs straight from flops
  assign reg_rdata = st_r.rdata;
  assign overflow_flag = st_r.interrupt_control[TPS_INT_FLAG_BIT];
  assign watchdog_timeout = st_r.wdt_timeout;
  assign port_a_direction = st_r.porta_dir;
endmodule : tps_timer
`default_nettype wire

// ### bench/tps_timer_properties.sv
// Port checker for the timer block with shared prescaler
`timescale 1ns/1ps
`default_nettype none
module tps_timer_checker (
  input wire logic clk,
  input wire logic rst_n,
  input wire tps_pkg::tps_reg_req_s reg_req,
  input wire logic [7:0] reg_rdata,
  input wire logic sleep_active,
  input wire logic overflow_flag,
  input wire logic [5:0] port_a_direction
);
  import tps_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic ic_hit, dir_hit, mapped, ic_clr;
  logic [7:0] opt_r;
  // Address decode shared by the properties
  assign ic_hit = reg_req.addr == TPS_ADDR_INTCTL_LO || reg_req.addr == TPS_ADDR_INTCTL_HI;
  assign dir_hit = reg_req.addr == TPS_ADDR_PORTA_DIR;
  assign mapped = ic_hit || dir_hit || reg_req.addr inside {TPS_ADDR_TIMER_COUNT, TPS_ADDR_OPTION};
  assign ic_clr = reg_req.wr && ic_hit && !reg_req.wdata[TPS_INT_FLAG_BIT];
  // Shadow of the option register, to compare readback
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) opt_r <= TPS_OPTION_RST;
    else if (reg_req.wr && reg_req.addr == TPS_ADDR_OPTION) opt_r <= reg_req.wdata;
  end
  // Flag seen high, then low one cycle later
  sequence flag_drop_s;
    overflow_flag ##1 !overflow_flag;
  endsequence
  unmapped_read_a: assert property (reg_req.rd && !mapped |=> reg_rdata == 8'h00)
    else $error("unmapped read returned data");
  flag_clear_a: assert property (flag_drop_s |-> $past(ic_clr))
    else $error("overflow flag dropped without a clearing write");
  sleep_hold_a: assert property ($rose(overflow_flag) && !$past(reg_req.wr && ic_hit) |-> !$past(sleep_active))
    else $error("overflow flag set while asleep");
  flag_read_a: assert property (reg_req.rd && ic_hit |=> reg_rdata[TPS_INT_FLAG_BIT] == $past(overflow_flag))
    else $error("overflow flag readback wrong");
  opt_read_a: assert property (reg_req.rd && reg_req.addr == TPS_ADDR_OPTION |=> reg_rdata == $past(opt_r))
    else $error("option readback wrong");
  dir_write_a: assert property (reg_req.wr && dir_hit |=> port_a_direction == $past(reg_req.wdata[5:0]))
    else $error("direction write lost");
  dir_hold_a: assert property (!(reg_req.wr && dir_hit) |=> $stable(port_a_direction))
    else $error("direction changed without a write");
  rdata_hold_a: assert property (!reg_req.rd |=> $stable(reg_rdata))
    else $error("read data changed without a read");
endmodule : tps_timer_checker
bind tps_timer tps_timer_checker tps_timer_checker_inst (.clk(clk), .rst_n(rst_n), .reg_req(reg_req),
  .reg_rdata(reg_rdata), .sleep_active(sleep_active), .overflow_flag(overflow_flag),
  .port_a_direction(port_a_direction));
`default_nettype wire

// ### bench/tps_timer_bench.sv
// Self-checking testbench for the timer block with shared prescaler
`timescale 1ns/1ps
`default_nettype none
module tps_timer_bench;
  import tps_pkg::*;
  logic clk, rst_n, pin, slp, ovf, wto, wdc, wtick;
  tps_reg_req_s req;
  logic [7:0] rdata;
  logic [5:0] dir;
  int err_count, check_count, cyc;
  // Watchdog inputs driven only by the assignment and wrap scenarios at the end
  tps_timer tps_timer_inst (.clk(clk), .rst_n(rst_n), .reg_req(req), .reg_rdata(rdata),
    .external_count_pin(pin), .sleep_active(slp), .watchdog_clear_instruction(wdc),
    .watchdog_base_tick(wtick), .overflow_flag(ovf), .watchdog_timeout(wto), .port_a_direction(dir));
  // 40 MHz clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task automatic end_sim;
    if (err_count == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : end_sim
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Write strobe stands for one cycle
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(negedge clk);
    req.wr = 1'b0;
  endtask : wr
  // Read data is registered on the strobe edge, so it is settled at the next fall
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(negedge clk);
    req.rd = 1'b1;
    req.addr = a;
    @(negedge clk);
    req.rd = 1'b0;
    chk(rdata, exp);
  endtask : rd
  // One-cycle watchdog clear instruction
  task automatic wdog_clr;
    @(negedge clk);
    wdc = 1'b1;
    @(negedge clk);
    wdc = 1'b0;
  endtask : wdog_clr
  // Hang guard, above the 65536 cycles the full postscaler wrap needs
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 70000) begin
      err_count++;
      end_sim();
    end
  end
  initial begin
    req = '0;
    pin = 1'b0;
    slp = 1'b0;
    wdc = 1'b0;
    wtick = 1'b0;
    rst_n = 1'b0;
    repeat (20) @(negedge clk);
    rst_n = 1'b1;
    // Reset values, unmapped place, direction upper bits
    rd(TPS_ADDR_OPTION, 8'hFF);
    rd(TPS_ADDR_INTCTL_HI, 8'h00);
    rd(8'h02, 8'h00);
    wr(TPS_ADDR_PORTA_DIR, 8'hE5);
    rd(TPS_ADDR_PORTA_DIR, 8'h25);
    // Undivided internal count, stalled two cycles after a timer write
    wr(TPS_ADDR_OPTION, 8'h08);
    wr(TPS_ADDR_TIMER_COUNT, 8'hF0);
    for (int i = 0; i < 4; i++) rd(TPS_ADDR_TIMER_COUNT, 8'(i == 0 ? 8'hF0 : 8'hF0 + 2 * i - 1));
    // Every rate: wrap of FFh lands exactly 2^(r+1) ticks after the stall
    for (int r = 0; r < 8; r++) begin
      wr(TPS_ADDR_TIMER_COUNT, 8'h00);
      wr(TPS_ADDR_OPTION, 8'(r));
      wr(TPS_ADDR_INTCTL_LO, 8'h00);
      wr(TPS_ADDR_TIMER_COUNT, 8'hFF);
      repeat ((2 << r) + 1) @(negedge clk);
      chk({7'h0, ovf}, 8'h00);
      @(negedge clk);
      chk({7'h0, ovf}, 8'h01);
    end
    rd(TPS_ADDR_INTCTL_LO, 8'h04);
    // Sleep freezes the count
    wr(TPS_ADDR_OPTION, 8'h08);
    slp = 1'b1;
    wr(TPS_ADDR_TIMER_COUNT, 8'h10);
    repeat (6) @(negedge clk);
    rd(TPS_ADDR_TIMER_COUNT, 8'h10);
    slp = 1'b0;
    // Pin edges: six falls and five rises, cycles not counted
    for (int e = 0; e < 2; e++) begin
      pin = 1'b1;
      wr(TPS_ADDR_OPTION, 8'(8'h28 + 16 * e));
      wr(TPS_ADDR_TIMER_COUNT, 8'h00);
      repeat (3) @(negedge clk);
      repeat (5) begin
        pin = 1'b0;
        repeat (2) @(negedge clk);
        pin = 1'b1;
        repeat (2) @(negedge clk);
      end
      pin = 1'b0;
      repeat (3) @(negedge clk);
      rd(TPS_ADDR_TIMER_COUNT, 8'(5 + e));
    end
    // Watchdog clear empties a part-filled prescaler before it moves to the timer
    wr(TPS_ADDR_OPTION, 8'h2A);
    wr(TPS_ADDR_TIMER_COUNT, 8'h00);
    wdog_clr();
    wtick = 1'b1;
    repeat (3) @(negedge clk);
    wtick = 1'b0;
    wdog_clr();
    wr(TPS_ADDR_OPTION, 8'h22);
    // 1:8 on rising pin edges: seven edges leave the count, the eighth moves it
    for (int k = 0; k < 2; k++) begin
      repeat (k == 0 ? 7 : 1) begin
        pin = 1'b1;
        repeat (2) @(negedge clk);
        pin = 1'b0;
        repeat (2) @(negedge clk);
      end
      rd(TPS_ADDR_TIMER_COUNT, 8'(k));
    end
    // Timer to watchdog move in the safe order, then one full 1:1 postscaler wrap
    wdog_clr();
    wr(TPS_ADDR_TIMER_COUNT, 8'h00);
    wr(TPS_ADDR_OPTION, 8'h2F);
    wdog_clr();
    wr(TPS_ADDR_OPTION, 8'h28);
    wtick = 1'b1;
    repeat (65535) @(negedge clk);
    chk({7'h0, wto}, 8'h00);
    @(negedge clk);
    chk({7'h0, wto}, 8'h01);
    wtick = 1'b0;
    @(negedge clk);
    chk({7'h0, wto}, 8'h00);
    end_sim();
  end
endmodule : tps_timer_bench
`default_nettype wire
